// File: rtl/slfc_classifier.sv
// Frame classifier top: control message and data frame sorting with checks
`timescale 1ns/1ps
`include "slfc_cfg.svh"
module slfc_classifier
    import slfc_pkg::*;
#(
    parameter int NUM_PORTS = 126,   // Physical ports, 1 to 126
    parameter int TBL_DEPTH = 8      // Outstanding table entries
) (
    input  wire logic        core_clk_i,   // Core clock
    input  wire logic        resetn_i,     // Synchronous reset, active low
    input  wire logic        wb_cyc_i,     // Wishbone cycle
    input  wire logic        wb_stb_i,     // Wishbone strobe
    input  wire logic        wb_we_i,      // Wishbone write
    input  wire logic [7:0]  wb_adr_i,     // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,     // Wishbone byte enables
    input  wire logic [31:0] wb_dat_i,     // Wishbone write data
    output logic      [31:0] wb_dat_o,     // Wishbone read data
    output logic             wb_ack_o,     // Wishbone acknowledge
    input  wire logic        rx_valid_i,   // Received byte valid
    input  wire logic [7:0]  rx_data_i,    // Received data byte
    input  wire logic        rx_sof_i,     // First byte of frame
    input  wire logic        rx_eof_i,     // Last byte of frame
    input  wire logic [7:0]  rx_chan_i,    // Channel component, valid at first byte
    input  wire logic [1:0]  rx_ftype_i,   // Frame type, valid at first byte
    input  wire logic        rx_cut_i,     // Frame is cut-through routed
    output logic             msg_valid_o,  // Message byte valid
    output logic      [7:0]  msg_data_o,   // Message byte
    output logic             msg_last_o,   // Message last byte
    output logic             msg_err_o,    // Message terminated, with last
    output logic      [1:0]  msg_ftype_o,  // Frame type of message
    output logic             dat_valid_o,  // Data frame byte valid
    output logic      [7:0]  dat_data_o,   // Data frame byte
    output logic             dat_last_o,   // Data frame last byte
    output logic             dat_err_o,    // Data frame too short, with last
    output logic      [7:0]  dat_chan_o,   // Data frame channel
    input  wire logic        tx_valid_i,   // Transmit byte valid
    input  wire logic [7:0]  tx_data_i,    // Transmit byte
    input  wire logic        tx_rsvd_i,    // Transmit byte is reserved
    output logic             tx_valid_o,   // Transmit byte valid out
    output logic      [7:0]  tx_data_o,    // Transmit byte out
    output logic      [6:0]  tx_port_o     // Selected physical port
);
    typedef struct packed {
        slfc_state_type st;
        logic [5:0]     idx;
        logic           err;
        logic           cut;
        logic [7:0]     func;
        logic [15:0]    tag;
        logic           msg_valid;
        logic [7:0]     msg_data;
        logic           msg_last;
        logic           msg_err;
        logic [1:0]     msg_ftype;
        logic           dat_valid;
        logic [7:0]     dat_data;
        logic           dat_last;
        logic           dat_err;
        logic [7:0]     dat_chan;
        logic           tx_valid;
        logic [7:0]     tx_data;
        logic [6:0]     port;
        logic [7:0]     ctrl;
        logic [31:0]    rsvd;
        logic [15:0]    last_tag;
        logic [7:0]     n_msg;
        logic [7:0]     n_drop;
        logic           cpl_v;
        logic [15:0]    cpl_tag;
        logic           cmd_v;
        logic [31:0]    cmd;
        logic           ack;
        logic [31:0]    rdat;
    } slfc_top_state_type;

    slfc_top_state_type q;
    slfc_top_state_type d;
    logic [5:0]         nidx;
    logic               bad;
    logic               fin;
    logic               fn_ok;
    logic [31:0]        wmask;
    logic               wb_req;

    slfc_tbl_if tbl_ch ();

    // ==========================================================
    // Task table
    slfc_tag_table #(
        .DEPTH      (TBL_DEPTH)
    ) u_table (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .tb         (tbl_ch.tbl)
    );

    // Table command fields from the last command word
    assign tbl_ch.cmd_v   = q.cmd_v;
    assign tbl_ch.op      = slfc_op_type'(q.cmd[27:25]);
    assign tbl_ch.tag     = q.cmd[15:0];
    assign tbl_ch.path    = q.cmd[23:16];
    assign tbl_ch.conf    = q.cmd[24];
    assign tbl_ch.hold    = q.ctrl[`SLFC_CTRL_HOLD];
    assign tbl_ch.cpl_v   = q.cpl_v;
    assign tbl_ch.cpl_tag = q.cpl_tag;

    // Function code check: only codes of the message set are legal
    always_comb begin
        case (rx_data_i)
            8'h03, 8'h10, 8'h11, 8'h12, 8'h20, 8'h21,
            8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35: fn_ok = 1'b1;
            default:                                  fn_ok = 1'b0;
        endcase
    end

    // Byte-lane write mask from wishbone selects
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
        end
    end

    assign wb_req = wb_cyc_i && wb_stb_i && !q.ack;

    // ==========================================================
    // Next-state logic
    always_comb begin
        d           = q;
        nidx        = q.idx;
        bad         = 1'b0;
        fin         = 1'b0;
        d.msg_valid = 1'b0;
        d.msg_last  = 1'b0;
        d.msg_err   = 1'b0;
        d.dat_valid = 1'b0;
        d.dat_last  = 1'b0;
        d.dat_err   = 1'b0;
        d.cpl_v     = 1'b0;
        d.cmd_v     = 1'b0;
        d.ack       = 1'b0;

        // Receive sorting, byte stream is msb-first within bytes
        if (rx_valid_i) begin
            if (rx_sof_i) begin
                nidx  = `SLFC_IDX_CODE;
                d.err = 1'b0;
                d.cut = rx_cut_i;
                if (!q.ctrl[`SLFC_CTRL_EN]) begin
                    d.st = SLFC_ST_IDLE;
                end else if (rx_chan_i == `SLFC_CTRL_CHAN) begin
                    d.st        = SLFC_ST_MSG;
                    d.msg_ftype = rx_ftype_i;
                    // Non-application frame type is a message fault unless cut-through
                    d.err = (rx_ftype_i != `SLFC_FT_APP) && !rx_cut_i;
                end else begin
                    d.st       = SLFC_ST_DAT;
                    d.dat_chan = rx_chan_i;
                end
            end else if (q.idx != `SLFC_IDX_SAT) begin
                nidx = q.idx + 6'h01;
            end
            d.idx = nidx;
            fin   = rx_eof_i;

            case (rx_sof_i ? d.st : q.st)
                SLFC_ST_MSG: begin
                    d.msg_valid = 1'b1;
                    d.msg_data  = rx_data_i;
                    d.msg_last  = rx_eof_i;
                    if (!d.cut) begin
                        // Leading code byte then a known function code
                        if (nidx == `SLFC_IDX_CODE && rx_data_i != `SLFC_MSG_CODE)
                            bad = 1'b1;
                        if (nidx == `SLFC_IDX_FUNC && !fn_ok)
                            bad = 1'b1;
                        // Reserved bytes marked by software must be zero
                        if (nidx < `SLFC_MAX_MSG && q.rsvd[nidx[4:0]] &&
                            rx_data_i != 8'h00)
                            bad = 1'b1;
                        // Oversize message cannot be a single message
                        if (nidx >= `SLFC_MAX_MSG)
                            bad = 1'b1;
                    end
                    if (nidx == `SLFC_IDX_FUNC)
                        d.func = rx_data_i;
                    // Tag assembled most significant byte first
                    if (nidx == `SLFC_IDX_TAGH)
                        d.tag[15:8] = rx_data_i;
                    if (nidx == `SLFC_IDX_TAGL)
                        d.tag[7:0] = rx_data_i;
                    d.err = d.err || bad;
                    if (fin) begin
                        // Runts are never valid frames
                        d.msg_err = d.err || (nidx < `SLFC_MIN_CHARS - 6'h01);
                        d.st      = SLFC_ST_IDLE;
                        if (d.msg_err) begin
                            d.n_drop = q.n_drop + 8'h01;
                        end else begin
                            d.n_msg    = q.n_msg + 8'h01;
                            d.last_tag = d.tag;
                            // Status or response retires its task unless cut-through
                            if (d.func == `SLFC_FN_STAT || d.func == `SLFC_FN_RESP) begin
                                d.cpl_v   = !d.cut;
                                d.cpl_tag = d.tag;
                            end
                        end
                    end
                end
                SLFC_ST_DAT: begin
                    d.dat_valid = 1'b1;
                    d.dat_data  = rx_data_i;
                    d.dat_last  = rx_eof_i;
                    if (fin) begin
                        d.dat_err = (nidx < `SLFC_MIN_CHARS - 6'h01);
                        d.st      = SLFC_ST_IDLE;
                    end
                end
                default: d.st = SLFC_ST_IDLE;
            endcase
        end

        // Transmit path, reserved bytes forced to zero, no end-to-end ack
        d.tx_valid = tx_valid_i;
        d.tx_data  = tx_rsvd_i ? 8'h00 : tx_data_i;

        // Wishbone slave, one-cycle answer
        if (wb_req) begin
            d.ack  = 1'b1;
            d.rdat = 32'h0000_0000;
            if (wb_adr_i == `SLFC_REG_CTRL) begin
                d.rdat = {24'h00_0000, q.ctrl};
                if (wb_we_i)
                    d.ctrl = (q.ctrl & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
            end else if (wb_adr_i == `SLFC_REG_RSVD) begin
                d.rdat = q.rsvd;
                if (wb_we_i)
                    d.rsvd = (q.rsvd & ~wmask) | (wb_dat_i & wmask);
            end else if (wb_adr_i == `SLFC_REG_STATUS) begin
                d.rdat = {tbl_ch.count, 4'h0, tbl_ch.dup, tbl_ch.ok,
                          tbl_ch.full, q.ctrl[`SLFC_CTRL_HOLD],
                          q.n_drop, q.n_msg};
            end else if (wb_adr_i == `SLFC_REG_TAG) begin
                d.rdat = {16'h0000, q.last_tag};
            end else if (wb_adr_i == `SLFC_REG_TBL) begin
                d.rdat = q.cmd;
                if (wb_we_i) begin
                    d.cmd   = (q.cmd & ~wmask) | (wb_dat_i & wmask);
                    d.cmd_v = 1'b1;
                end
            end else if (wb_adr_i == `SLFC_REG_PORT) begin
                d.rdat = {25'h000_0000, q.port};
                if (wb_we_i && wb_sel_i[0]) begin
                    // Port index clamps to the node's last port, NUM_PORTS - 1
                    if (wb_dat_i[6:0] > 7'(NUM_PORTS - 1))
                        d.port = 7'(NUM_PORTS - 1);
                    else
                        d.port = wb_dat_i[6:0];
                end
            end
        end

        if (!resetn_i) begin
            d      = '0;
            d.st   = SLFC_ST_IDLE;
            d.ctrl = `SLFC_CTRL_RST;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge core_clk_i) begin
        q <= d;
    end

    // Outputs come straight from the state register
    assign wb_dat_o    = q.rdat;
    assign wb_ack_o    = q.ack;
    assign msg_valid_o = q.msg_valid;
    assign msg_data_o  = q.msg_data;
    assign msg_last_o  = q.msg_last;
    assign msg_err_o   = q.msg_err;
    assign msg_ftype_o = q.msg_ftype;
    assign dat_valid_o = q.dat_valid;
    assign dat_data_o  = q.dat_data;
    assign dat_last_o  = q.dat_last;
    assign dat_err_o   = q.dat_err;
    assign dat_chan_o  = q.dat_chan;
    assign tx_valid_o  = q.tx_valid;
    assign tx_data_o   = q.tx_data;
    assign tx_port_o   = q.port;
endmodule : slfc_classifier

// File: rtl/slfc_cfg.svh
// Register offsets, field positions and protocol constants of the frame classifier
`ifndef SLFC_CFG_SVH
`define SLFC_CFG_SVH
`define SLFC_REG_CTRL     8'h00
`define SLFC_REG_RSVD     8'h04
`define SLFC_REG_STATUS   8'h08
`define SLFC_REG_TAG      8'h0C
`define SLFC_REG_TBL      8'h10
`define SLFC_REG_PORT     8'h14
`define SLFC_CTRL_EN      0
`define SLFC_CTRL_HOLD    1
`define SLFC_CTRL_RST     8'h01
`define SLFC_MSG_CODE     8'h83
`define SLFC_CTRL_CHAN    8'h00
`define SLFC_FT_APP       2'h1
`define SLFC_MIN_CHARS    6'h06
`define SLFC_MAX_MSG      6'h20
`define SLFC_IDX_CODE     6'h00
`define SLFC_IDX_FUNC     6'h01
`define SLFC_IDX_TAGH     6'h02
`define SLFC_IDX_TAGL     6'h03
`define SLFC_IDX_SAT      6'h3F
`define SLFC_FN_RESP      8'h03
`define SLFC_FN_STAT      8'h11
`endif

// File: rtl/slfc_pkg.sv
// Types shared by the frame classifier and its outstanding-task table
package slfc_pkg;
    typedef enum logic [1:0] {
        SLFC_ST_IDLE,
        SLFC_ST_MSG,
        SLFC_ST_DAT
    } slfc_state_type;

    typedef enum logic [2:0] {
        SLFC_OP_NONE,
        SLFC_OP_ALLOC,
        SLFC_OP_FREE,
        SLFC_OP_REROUTE
    } slfc_op_type;

    typedef struct packed {
        logic        vld;
        logic        conf;
        logic [7:0]  path;
        logic [15:0] tag;
    } slfc_entry_type;
endpackage : slfc_pkg

// File: rtl/slfc_tbl_if.sv
// Command and completion channel between classifier and task table
`timescale 1ns/1ps
interface slfc_tbl_if;
    import slfc_pkg::*;
    logic        cmd_v;
    slfc_op_type op;
    logic [15:0] tag;
    logic [7:0]  path;
    logic        conf;
    logic        hold;
    logic        cpl_v;
    logic [15:0] cpl_tag;
    logic        ok;
    logic        dup;
    logic [7:0]  count;
    logic        full;
    modport ctl (output cmd_v, op, tag, path, conf, hold, cpl_v, cpl_tag,
                 input ok, dup, count, full);
    modport tbl (input cmd_v, op, tag, path, conf, hold, cpl_v, cpl_tag,
                 output ok, dup, count, full);
endinterface : slfc_tbl_if

// File: rtl/slfc_tag_table.sv
// Outstanding command and task table with unique tags and path rerouting
`timescale 1ns/1ps
module slfc_tag_table
    import slfc_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input  wire logic core_clk_i,   // Core clock
    input  wire logic resetn_i,     // Synchronous reset, active low
    slfc_tbl_if.tbl   tb            // Table channel
);
    typedef struct packed {
        slfc_entry_type [DEPTH-1:0] ent;
        logic                       ok;
        logic                       dup;
    } slfc_tbl_state_type;

    slfc_tbl_state_type q;
    slfc_tbl_state_type d;
    logic [7:0]         cnt;
    logic               hit;
    logic               placed;

    // ==========================================================
    // Table update
    always_comb begin
        d      = q;
        cnt    = 8'h00;
        hit    = 1'b0;
        placed = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            cnt = cnt + 8'(q.ent[i].vld);
            if (q.ent[i].vld && q.ent[i].tag == tb.tag) hit = 1'b1;
        end
        if (tb.cmd_v) begin
            d.ok  = 1'b0;
            d.dup = 1'b0;
            case (tb.op)
                SLFC_OP_ALLOC: begin
                    d.dup = hit;
                    if (!hit && !tb.hold) begin
                        for (int i = 0; i < DEPTH; i++) begin
                            if (!q.ent[i].vld && !placed) begin
                                d.ent[i] = {1'b1, tb.conf, tb.path, tb.tag};
                                placed   = 1'b1;
                            end
                        end
                    end
                    d.ok = placed;
                end
                SLFC_OP_FREE: begin
                    for (int i = 0; i < DEPTH; i++) begin
                        if (q.ent[i].vld && q.ent[i].tag == tb.tag) d.ent[i].vld = 1'b0;
                    end
                    d.ok = hit;
                end
                SLFC_OP_REROUTE: begin
                    // Failed path in tag low byte, alternate path in path field
                    for (int i = 0; i < DEPTH; i++) begin
                        if (q.ent[i].vld && q.ent[i].conf && q.ent[i].path == tb.tag[7:0])
                            d.ent[i].path = tb.path;
                    end
                    d.ok = 1'b1;
                end
                default: d.ok = 1'b0;
            endcase
        end
        // Completion message retires its task
        if (tb.cpl_v) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (q.ent[i].vld && q.ent[i].tag == tb.cpl_tag) d.ent[i].vld = 1'b0;
            end
        end
        if (!resetn_i) d = '0;
    end

    // State register
    always_ff @(posedge core_clk_i) begin
        q <= d;
    end

    assign tb.ok    = q.ok;
    assign tb.dup   = q.dup;
    assign tb.count = cnt;
    assign tb.full  = (cnt == 8'(DEPTH));
endmodule : slfc_tag_table

// File: bench/slfc_monitor.sv
// Port checker for the frame classifier
`timescale 1ns/1ps
module slfc_monitor #(
    parameter int NUM_PORTS = 126    // Physical ports
) (
    input wire logic       core_clk_i,  // Clock
    input wire logic       resetn_i,    // Reset
    input wire logic       wb_cyc_i,    // Cycle
    input wire logic       wb_stb_i,    // Strobe
    input wire logic       wb_ack_o,    // Ack
    input wire logic       rx_valid_i,  // Rx valid
    input wire logic [7:0] rx_data_i,   // Rx byte
    input wire logic       rx_sof_i,    // Rx first
    input wire logic [7:0] rx_chan_i,   // Rx channel
    input wire logic [1:0] rx_ftype_i,  // Rx type
    input wire logic       msg_valid_o, // Msg valid
    input wire logic [7:0] msg_data_o,  // Msg byte
    input wire logic       msg_last_o,  // Msg last
    input wire logic       msg_err_o,   // Msg error
    input wire logic [1:0] msg_ftype_o, // Msg type
    input wire logic       dat_valid_o, // Data valid
    input wire logic [7:0] dat_chan_o,  // Data channel
    input wire logic       tx_valid_i,  // Tx valid in
    input wire logic [7:0] tx_data_i,   // Tx byte in
    input wire logic       tx_rsvd_i,   // Tx reserved
    input wire logic       tx_valid_o,  // Tx valid out
    input wire logic [7:0] tx_data_o,   // Tx byte out
    input wire logic [6:0] tx_port_o    // Port
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // ==========================================
    // Bus handshake and stream checks
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_msg_sof;
        rx_valid_i && rx_sof_i && rx_chan_i == 8'h00;
    endsequence
    a_wb_ack_once:
        assert property (s_req |=> s_ans) else $error("ack not a single pulse");
    a_msg_route:
        assert property (s_msg_sof |=> msg_valid_o && !dat_valid_o
            && msg_data_o == $past(rx_data_i)) else $error("message misrouted");
    a_ftype_carry:
        assert property (s_msg_sof |=> msg_ftype_o == $past(rx_ftype_i))
            else $error("frame type lost");
    a_dat_route:
        assert property (rx_valid_i && rx_sof_i && rx_chan_i != 8'h00 |=> dat_valid_o
            && !msg_valid_o && dat_chan_o == $past(rx_chan_i)) else $error("data misrouted");
    a_err_on_last:
        assert property (msg_err_o |-> msg_valid_o && msg_last_o) else $error("err off last");
    a_no_idle_out:
        assert property (!rx_valid_i |=> !msg_valid_o && !dat_valid_o)
            else $error("output without input");
    a_tx_rsvd_zero:
        assert property (tx_valid_i && tx_rsvd_i |=> tx_valid_o && tx_data_o == 8'h00)
            else $error("reserved byte not zero");
    a_tx_bit_order:
        assert property (tx_valid_i && !tx_rsvd_i |=> tx_valid_o
            && tx_data_o == $past(tx_data_i)) else $error("tx byte altered");
    a_port_clamp:
        assert property (tx_port_o <= NUM_PORTS - 1) else $error("port out of range");
endmodule : slfc_monitor

// File: bench/slfc_peer.sv
// Peer node model sending frames into the receive side
`timescale 1ns/1ps
module slfc_peer (
    input  wire logic       core_clk_i, // Clock
    output logic            rx_valid_o, // Byte valid
    output logic      [7:0] rx_data_o,  // Byte
    output logic            rx_sof_o,   // First byte
    output logic            rx_eof_o,   // Last byte
    output logic      [7:0] rx_chan_o,  // Channel
    output logic      [1:0] rx_ftype_o, // Frame type
    output logic            rx_cut_o    // Cut-through
);
    // Idle lines at time zero
    initial begin
        {rx_valid_o, rx_data_o, rx_sof_o, rx_eof_o} = '0;
        {rx_chan_o, rx_ftype_o, rx_cut_o} = '0;
    end
    // Sends n bytes in order, byte 0 from the top of b
    task send(input logic [7:0] ch, input logic [1:0] ft, input logic ct,
              input logic [63:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o  <= b[63-8*i -: 8];
            rx_sof_o   <= (i == 0);
            rx_eof_o   <= (i == n - 1);
            rx_chan_o  <= ch;
            rx_ftype_o <= ft;
            rx_cut_o   <= ct;
        end
        @(posedge core_clk_i);
        // Released data and channel lines show the inverse of their last value
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~rx_data_o;
        rx_chan_o  <= ~rx_chan_o;
    endtask : send
endmodule : slfc_peer

// File: bench/storage_link_frame_classifier_tb.sv
// Self-checking bench for the frame classifier
`timescale 1ns/1ps
`include "slfc_cfg.svh"
module storage_link_frame_classifier_tb;
    logic        core_clk_i, resetn_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0]  wb_adr_i = 0, rx_data_i, rx_chan_i, msg_data_o, dat_data_o, dat_chan_o;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
    logic        wb_ack_o, rx_valid_i, rx_sof_i, rx_eof_i, rx_cut_i, fmsg, ferr;
    logic [1:0]  rx_ftype_i, msg_ftype_o;
    logic        msg_valid_o, msg_last_o, msg_err_o, dat_valid_o, dat_last_o, dat_err_o;
    logic        tx_valid_i = 0, tx_rsvd_i = 0, tx_valid_o;
    logic [7:0]  tx_data_i = 0, tx_data_o, mq[$];
    logic [6:0]  tx_port_o;
    int          bad_count = 0, num_checks = 0;
    slfc_classifier u_dut (.core_clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_valid_i, .rx_data_i,
        .rx_sof_i, .rx_eof_i, .rx_chan_i, .rx_ftype_i, .rx_cut_i, .msg_valid_o,
        .msg_data_o, .msg_last_o, .msg_err_o, .msg_ftype_o, .dat_valid_o, .dat_data_o,
        .dat_last_o, .dat_err_o, .dat_chan_o, .tx_valid_i, .tx_data_i, .tx_rsvd_i,
        .tx_valid_o, .tx_data_o, .tx_port_o);
    slfc_peer u_peer (.core_clk_i, .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
        .rx_sof_o(rx_sof_i), .rx_eof_o(rx_eof_i), .rx_chan_o(rx_chan_i),
        .rx_ftype_o(rx_ftype_i), .rx_cut_o(rx_cut_i));
    // ==========================================
    // Clock, capture and common tasks
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // Collect both output streams
    always @(posedge core_clk_i) begin
        if (msg_valid_o === 1'b1) begin
            mq.push_back(msg_data_o);
            fmsg = 1'b1;
            if (msg_last_o) ferr = msg_err_o;
        end
        if (dat_valid_o === 1'b1) begin
            mq.push_back(dat_data_o);
            fmsg = 1'b0;
            if (dat_last_o) ferr = dat_err_o;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        for (int i = 0; i < 50 && wb_ack_o !== 1'b1; i++) @(posedge core_clk_i);
        // A bus that never answers counts as a mismatch
        if (wb_ack_o !== 1'b1) bad_count++;
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    task frame(input logic [7:0] ch, input logic [1:0] ft, input logic ct,
               input logic [63:0] b, input int n, input logic e);
        mq.delete();
        ferr = 1'bx;
        u_peer.send(ch, ft, ct, b, n);
        repeat (3) @(posedge core_clk_i);
        chk(mq.size(), n);
        foreach (mq[i]) chk(mq[i], b[63-8*i -: 8]);
        chk(ferr, e);
        chk(fmsg, ch == 8'h00);
        if (ch != 8'h00) chk(dat_chan_o, ch);
    endtask : frame
    task print_verdict;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    // ==========================================
    // Scenarios
    task t_regs;
        wb(0, `SLFC_REG_CTRL, 0);
        chk(rd, 32'h00000001);
        wb(1, 8'h40, 32'hFFFFFFFF);
        wb(0, 8'h40, 0);
        chk(rd, 32'h00000000);
        wb(1, `SLFC_REG_STATUS, 32'h000000FF);
        wb(0, `SLFC_REG_STATUS, 0);
        chk(rd, 32'h00000000);
        wb(1, `SLFC_REG_PORT, 32'h0000007F);
        wb(0, `SLFC_REG_PORT, 0);
        chk(rd, 32'h0000007D);
        chk(tx_port_o, 32'h0000007D);
    endtask : t_regs
    task t_rx;
        frame(8'h00, 2'h1, 0, 64'h8310123400000000, 6, 0);
        frame(8'h00, 2'h1, 0, 64'h8410123400000000, 6, 1);
        frame(8'h00, 2'h1, 0, 64'h8340123400000000, 6, 1);
        frame(8'h00, 2'h2, 0, 64'h8310123400000000, 6, 1);
        frame(8'h00, 2'h1, 0, 64'h8310123400000000, 5, 1);
        frame(8'h00, 2'h1, 0, 64'h8310123455000000, 6, 0);
        wb(0, `SLFC_REG_STATUS, 0);
        chk(rd, 32'h00000402);
        wb(0, `SLFC_REG_TAG, 0);
        chk(rd, 32'h00001234);
        wb(1, `SLFC_REG_RSVD, 32'h00000010);
        frame(8'h00, 2'h1, 0, 64'h8310123455000000, 6, 1);
        frame(8'h00, 2'h1, 1, 64'h8410123455000000, 6, 0);
        wb(1, `SLFC_REG_RSVD, 0);
        frame(8'h05, 2'h1, 0, 64'h0102030405060708, 8, 0);
        frame(8'hC3, 2'h1, 0, 64'h0102030405060708, 5, 1);
    endtask : t_rx
    task t_tbl;
        wb(1, `SLFC_REG_TBL, 32'h03010AAA);
        wb(0, `SLFC_REG_STATUS, 0);
        chk(rd[31:16], 16'h0104);
        wb(1, `SLFC_REG_TBL, 32'h03010AAA);
        wb(0, `SLFC_REG_STATUS, 0);
        chk(rd[31:16], 16'h0108);
        wb(1, `SLFC_REG_CTRL, 32'h00000003);
        wb(1, `SLFC_REG_TBL, 32'h03010BBB);
        wb(0, `SLFC_REG_STATUS, 0);
        chk(rd[31:16], 16'h0101);
        wb(1, `SLFC_REG_CTRL, 32'h00000001);
        wb(1, `SLFC_REG_TBL, 32'h06020001);
        wb(0, `SLFC_REG_STATUS, 0);
        chk(rd[31:24], 8'h01);
        frame(8'h00, 2'h1, 0, 64'h83110AAA00000000, 6, 0);
        wb(0, `SLFC_REG_STATUS, 0);
        chk(rd[31:24], 8'h00);
        for (int i = 0; i < 9; i++) wb(1, `SLFC_REG_TBL, 32'h02000100 + i);
        wb(0, `SLFC_REG_STATUS, 0);
        chk(rd[31:16], 16'h0802);
    endtask : t_tbl
    task t_tx;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk_i);
            {tx_valid_i, tx_rsvd_i, tx_data_i} <= {1'b1, i[0], 8'(8'hA5 + i)};
            @(posedge core_clk_i);
            #1 chk({tx_valid_o, tx_data_o}, i[0] ? 9'h100 : 9'h100 + (8'hA5 + i));
        end
        @(posedge core_clk_i);
        tx_valid_i <= 1'b0;
    endtask : t_tx
    // Main sequence and watchdog
    initial begin
        repeat (16) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_regs;
        t_rx;
        t_tbl;
        t_tx;
        print_verdict;
    end
    initial begin
        #200000;
        bad_count++;
        print_verdict;
    end
endmodule : storage_link_frame_classifier_tb
bind slfc_classifier slfc_monitor #(.NUM_PORTS(NUM_PORTS)) u_mon (.core_clk_i, .resetn_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_valid_i, .rx_data_i, .rx_sof_i, .rx_chan_i,
    .rx_ftype_i, .msg_valid_o, .msg_data_o, .msg_last_o, .msg_err_o, .msg_ftype_o,
    .dat_valid_o, .dat_chan_o, .tx_valid_i, .tx_data_i, .tx_rsvd_i, .tx_valid_o,
    .tx_data_o, .tx_port_o);
